// ### timer_pwm.sv
// Sixteen-bit down-counting timer, counter and PWM with an AHB-Lite register slave.
`timescale 1ns/100ps
`include "timer_pwm_cfg.svh"
module timer_pwm
   import timer_pwm_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Counting clock strobes from the routing fabric.
   input wire logic [2:0] tick_in,
   // Control inputs.
   input wire logic count_en_in,
   input wire logic tmr_reset_in,
   input wire logic capture_in,
   input wire logic kill_in,
   // Outputs.
   output logic cmp_out,
   output logic cmp_n_out,
   output logic tc_out,
   output logic irq_out
);

   ahb_phase_t aph_r;
   logic [31:0] hrdata_r;
   logic [`CFG_W-1:0] cfg_r;
   logic [15:0] period_r;
   logic [15:0] compare_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [15:0] capture_r;
   logic [7:0] dead_r;
   logic [`ST_W-1:0] status_r;
   logic [`ST_W-1:0] mask_r;
   run_state_t state_r;
   run_state_t state_nxt;
   logic tc_r;
   logic cmp_prev_r;
   logic cap_prev_r;
   pwm_pair_t pair;

   // Bus address phase: only whole-word accesses are taken; others get OKAY and no effect.
   wire take = hsel && htrans[1] && hready && ce;
   wire word_ok = (hsize == `HSIZE_WORD) && (haddr[31:8] == 24'h000000);
   wire [7:0] rd_addr = haddr[7:0];

   // Data-phase write strobes, one per writable register; COUNT and CAPTURE have none.
   wire wr = aph_r.act && aph_r.write && ce;
   wire wr_ctrl = wr && (aph_r.addr == `OFF_CTRL);
   wire wr_period = wr && (aph_r.addr == `OFF_PERIOD);
   wire wr_compare = wr && (aph_r.addr == `OFF_COMPARE);
   wire wr_status = wr && (aph_r.addr == `OFF_STATUS);
   wire wr_mask = wr && (aph_r.addr == `OFF_MASK);
   wire wr_dead = wr && (aph_r.addr == `OFF_DEADBAND);

   // Configuration fields.
   wire [1:0] mode_bits = cfg_r[`CFG_MODE_LSB +: 2];
   wire [2:0] rel_bits = cfg_r[`CFG_CMP_LSB +: 3];
   wire [1:0] src_bits = cfg_r[`CFG_CLK_LSB +: 2];
   wire comp_en = cfg_r[`CFG_COMP_BIT];
   wire running = (state_r == st_count);

   // Selected counting clock strobe; bus clock source counts every cycle.
   wire tick = (src_bits == src_bus) ? 1'b1 :
               (src_bits == src_a) ? tick_in[0] :
               (src_bits == src_b) ? tick_in[1] : tick_in[2];

   // A counting step needs the run state and, in gated mode, the enable input.
   wire gate_ok = (mode_bits != run_gated) || count_en_in;
   wire step = ce && tick && running && gate_ok;
   wire at_zero = (count_r == 16'h0000);

   // Start is a run write while not counting; the reset input reloads at any time.
   wire start_w = wr_ctrl && hwdata[`CTRL_EN_BIT] && !running;
   wire stop_w = wr_ctrl && !hwdata[`CTRL_EN_BIT];
   wire load_now = start_w || (ce && tmr_reset_in);

   // Comparator with five relations.
   wire cmp_raw = (rel_bits == cmp_less) ? (count_r < compare_r) :
                  (rel_bits == cmp_less_or_equal) ? (count_r <= compare_r) :
                  (rel_bits == cmp_equal) ? (count_r == compare_r) :
                  (rel_bits == cmp_greater_or_equal) ? (count_r >= compare_r) :
                  (rel_bits == cmp_greater) ? (count_r > compare_r) : 1'b0;

   // Events: terminal count step, compare going true, capture edge.
   wire tc_ev = step && at_zero;
   wire cmp_ev = ce && cmp_raw && !cmp_prev_r;
   wire cap_edge = ce && tick && capture_in && !cap_prev_r;
   wire [`ST_W-1:0] ev = {cap_edge, cmp_ev, tc_ev};

   // Read multiplexer, evaluated in the address phase.
   wire [31:0] rd_mux =
      !word_ok ? 32'h00000000 :
      (rd_addr == `OFF_CTRL) ? {23'h000000, cfg_r, running} :
      (rd_addr == `OFF_PERIOD) ? {16'h0000, period_r} :
      (rd_addr == `OFF_COMPARE) ? {16'h0000, compare_r} :
      (rd_addr == `OFF_COUNT) ? {16'h0000, count_r} :
      (rd_addr == `OFF_CAPTURE) ? {16'h0000, capture_r} :
      (rd_addr == `OFF_STATUS) ? {29'h00000000, status_r} :
      (rd_addr == `OFF_MASK) ? {29'h00000000, mask_r} :
      (rd_addr == `OFF_DEADBAND) ? {24'h000000, dead_r} : 32'h00000000;

   // Bus address phase register and read data; zero wait states while not frozen.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_r <= '0;
         hrdata_r <= 32'h00000000;
      end else if (ce && hready) begin
         aph_r.act <= take && word_ok;
         aph_r.write <= hwrite;
         aph_r.addr <= rd_addr;
         if (take && !hwrite) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // Software-written registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= `RST_CFG;
         period_r <= `RST_PERIOD;
         compare_r <= `RST_COMPARE;
         mask_r <= `RST_STATUS;
         dead_r <= `RST_DEAD;
      end else begin
         if (wr_ctrl) cfg_r <= hwdata[`CTRL_CFG_LSB +: `CFG_W];
         if (wr_period) period_r <= hwdata[15:0];
         if (wr_compare) compare_r <= hwdata[15:0];
         if (wr_mask) mask_r <= hwdata[`ST_W-1:0];
         if (wr_dead) dead_r <= hwdata[7:0];
      end
   end

   // Run state: start, software stop, and the end of a one-shot period.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_idle: begin
            if (start_w) state_nxt = st_count;
         end
         st_count: begin
            if (stop_w) begin
               state_nxt = st_idle;
            end else if (tc_ev && (mode_bits == run_one_shot) && !load_now) begin
               state_nxt = st_done;
            end
         end
         st_done: begin
            if (start_w) state_nxt = st_count;
            else if (stop_w) state_nxt = st_idle;
         end
         default: state_nxt = st_idle;
      endcase
   end

   // Next count: a load wins, zero reloads the period, otherwise count down.
   always_comb begin
      count_nxt = count_r;
      if (load_now) begin
         count_nxt = period_r;
      end else if (step && at_zero) begin
         count_nxt = period_r;
      end else if (step) begin
         count_nxt = count_r - 16'h0001;
      end
   end

   // Counter, run state and terminal count level.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= `RST_COUNT;
         state_r <= st_idle;
         tc_r <= 1'b0;
      end else if (ce) begin
         count_r <= count_nxt;
         state_r <= state_nxt;
         tc_r <= (count_nxt == 16'h0000) && (state_nxt == st_count);
      end
   end

   // Capture sampling runs on the counting clock and never touches the counter.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture_r <= 16'h0000;
         cap_prev_r <= 1'b0;
         cmp_prev_r <= 1'b0;
      end else if (ce) begin
         cmp_prev_r <= cmp_raw;
         if (tick) cap_prev_r <= capture_in;
         if (cap_edge) capture_r <= count_r;
      end
   end

   // Sticky status bits; an event in the clearing cycle keeps the bit set.
   genvar gi;
   generate
      for (gi = 0; gi < `ST_W; gi = gi + 1) begin : g_status
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               status_r[gi] <= 1'b0;
            end else if (ev[gi]) begin
               status_r[gi] <= 1'b1;
            end else if (wr_status && hwdata[gi]) begin
               status_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Complementary compare pair with deadband and kill.
   pwm_deadband u_deadband (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .raw(cmp_raw),
      .kill(kill_in),
      .comp_en(comp_en),
      .dead(dead_r),
      .pair(pair)
   );

   // Output drive.
   assign cmp_out = pair.p;
   assign cmp_n_out = pair.n;
   assign tc_out = tc_r;
   assign irq_out = |(status_r & mask_r);
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // A counting step away from zero lowers the count by exactly one.
   chk_count_down: assert property (
      @(posedge hclk) disable iff (!hresetn)
      step && !load_now && !at_zero |=> count_r == $past(count_r) - 16'h0001)
      else $error("count did not step down by one");

   // Without a step or a load the counter holds.
   chk_count_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !step && !load_now |=> $stable(count_r))
      else $error("count moved without a counting clock");

   // A high compare output follows a true relation of the cycle before, outside kill.
   chk_cmp_relation: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cmp_out && $past(ce) |-> $past(cmp_raw) && !$past(kill_in))
      else $error("compare output high against its relation");

   // Start and the reset input load the period.
   chk_period_load: assert property (
      @(posedge hclk) disable iff (!hresetn)
      load_now |=> count_r == $past(period_r))
      else $error("period not loaded");

   // An event whose mask bit is set drives the interrupt from the next cycle.
   chk_irq_level: assert property (
      @(posedge hclk) disable iff (!hresetn)
      |(ev & mask_r) && !wr_mask |=> irq_out)
      else $error("interrupt missing after an unmasked event");

   // One shot stops at the end of its period.
   chk_oneshot_stop: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tc_ev && (mode_bits == run_one_shot) && !load_now && !wr_ctrl
      |=> state_r == st_done ##1 $stable(count_r) || state_r != st_done)
      else $error("one shot kept counting");

   // Gated mode holds the count while enable is low.
   chk_gated_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && (mode_bits == run_gated) && !count_en_in && !load_now
      |=> $stable(count_r))
      else $error("gated count moved while disabled");

   // A capture edge latches the count of that cycle.
   chk_capture_val: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cap_edge |=> capture_r == $past(count_r))
      else $error("capture value wrong");

   // Kill forces both compare outputs low by the next edge.
   chk_kill_outs: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && kill_in |=> !cmp_out && !cmp_n_out)
      else $error("outputs active under kill");

   // The pair is never active together, and a flip from cmp_out to cmp_n_out leaves a low gap.
   chk_pair_gap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !(cmp_out && cmp_n_out) && !($rose(cmp_n_out) && $past(cmp_out)))
      else $error("complementary outputs overlap");

   // Terminal count sets its status bit and the reload follows.
   chk_tc_reload: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tc_ev && !load_now |=> status_r[`ST_TC_BIT] && count_r == $past(period_r))
      else $error("terminal count not flagged or reloaded");

   // Leaving zero on a step drops the terminal count output again.
   chk_tc_single: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tc_ev && !load_now && (period_r != 16'h0000) |=> !tc_out)
      else $error("terminal count lasted past its step");

   // A start write puts the unit into the counting state.
   chk_start_run: assert property (
      @(posedge hclk) disable iff (!hresetn)
      start_w |=> running)
      else $error("start did not begin counting");

   // Without a capture edge the captured value is left alone.
   chk_capture_keep: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !cap_edge |=> $stable(capture_r))
      else $error("capture changed without an edge");

endmodule

// ### timer_pwm_cfg.svh
// Register offsets, field positions, reset values and counts of the timer/PWM unit.
`ifndef TIMER_PWM_CFG_SVH
`define TIMER_PWM_CFG_SVH

// Byte offsets of the registers on the bus.
`define OFF_CTRL 8'h00
`define OFF_PERIOD 8'h04
`define OFF_COMPARE 8'h08
`define OFF_COUNT 8'h0C
`define OFF_CAPTURE 8'h10
`define OFF_STATUS 8'h14
`define OFF_MASK 8'h18
`define OFF_DEADBAND 8'h1C

// Control word: bit 0 is run, bits 8:1 are the stored configuration.
`define CTRL_EN_BIT 0
`define CTRL_CFG_LSB 1
`define CFG_W 8

// Positions inside the stored configuration.
`define CFG_MODE_LSB 0
`define CFG_CMP_LSB 2
`define CFG_CLK_LSB 5
`define CFG_COMP_BIT 7

// Status and mask bit positions.
`define ST_TC_BIT 0
`define ST_CMP_BIT 1
`define ST_CAP_BIT 2
`define ST_W 3

// Reset values.
`define RST_CFG 8'h00
`define RST_PERIOD 16'hFFFF
`define RST_COMPARE 16'h0000
`define RST_COUNT 16'h0000
`define RST_DEAD 8'h00
`define RST_STATUS 3'h0

// Transfer size code of a whole word.
`define HSIZE_WORD 3'h2

`endif

// ### timer_pwm_pkg.sv
// Types shared by the timer/PWM unit and its deadband generator.
package timer_pwm_pkg;

   typedef enum logic [1:0] {
      run_free = 2'b00,
      run_one_shot = 2'b01,
      run_gated = 2'b10
   } run_mode_t;

   typedef enum logic [2:0] {
      cmp_less = 3'b000,
      cmp_less_or_equal = 3'b001,
      cmp_equal = 3'b010,
      cmp_greater_or_equal = 3'b011,
      cmp_greater = 3'b100
   } cmp_rel_t;

   typedef enum logic [1:0] {
      src_bus = 2'b00,
      src_a = 2'b01,
      src_b = 2'b10,
      src_c = 2'b11
   } clk_src_t;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_count = 2'b01,
      st_done = 2'b10
   } run_state_t;

   typedef struct packed {
      logic act;
      logic write;
      logic [7:0] addr;
   } ahb_phase_t;

   typedef struct packed {
      logic p;
      logic n;
   } pwm_pair_t;

endpackage

// ### pwm_deadband.sv
// Complementary output pair with deadband and kill override.
`timescale 1ns/100ps
`include "timer_pwm_cfg.svh"
module pwm_deadband
   import timer_pwm_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Raw compare level and controls.
   input wire logic raw,
   input wire logic kill,
   input wire logic comp_en,
   input wire logic [7:0] dead,
   // Registered output pair.
   output pwm_pair_t pair
);

   logic raw_r;
   logic [7:0] gap_r;
   pwm_pair_t pair_r;

   // A level is only passed on once it is stable and the gap has run out.
   wire changed = (raw != raw_r);
   wire settled = !changed && (gap_r == 8'h00);

   // Each edge of the raw level restarts the gap in which both outputs are low.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_r <= 1'b0;
         gap_r <= 8'h00;
      end else if (ce) begin
         raw_r <= raw;
         if (changed) begin
            gap_r <= dead;
         end else if (gap_r != 8'h00) begin
            gap_r <= gap_r - 8'h01;
         end
      end
   end

   // Outputs need opposite raw levels, so they can never be high together.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pair_r <= '0;
      end else if (ce) begin
         pair_r.p <= !kill && settled && raw;
         pair_r.n <= !kill && settled && !raw && comp_en;
      end
   end

   assign pair = pair_r;

endmodule

// ### tick_fabric.sv
// Routing-fabric model that supplies the three counting-clock strobes.
`timescale 1ns/100ps
module tick_fabric (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Strobes, one hclk wide, every 2, 3 and 4 cycles.
   output logic [2:0] tick_in
);
   logic c2_r;
   logic [1:0] c3_r;
   logic [1:0] c4_r;

   // Free-running dividers; each strobe fires once per divider wrap.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c2_r <= 1'b0;
         c3_r <= 2'h0;
         c4_r <= 2'h0;
         tick_in <= 3'h0;
      end else begin
         c2_r <= ~c2_r;
         c3_r <= (c3_r == 2'h2) ? 2'h0 : c3_r + 2'h1;
         c4_r <= c4_r + 2'h1;
         tick_in <= {c4_r == 2'h3, c3_r == 2'h2, c2_r};
      end
   end
endmodule

// ### testbench.sv
// Self-checking testbench of the timer/PWM unit.
`timescale 1ns/100ps
`include "timer_pwm_cfg.svh"
module testbench
   import timer_pwm_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = `HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic count_en_in = 1'b0;
   logic tmr_reset_in = 1'b0;
   logic capture_in = 1'b0;
   logic kill_in = 1'b0;
   logic ce = 1'b1;
   logic [31:0] rng_r = 32'h0000FD9A;
   wire logic hreadyout, hresp, cmp_out, cmp_n_out, tc_out, irq_out;
   wire logic [31:0] hrdata;
   wire logic [2:0] tick_in;
   int fails = 0;
   int n_checks = 0;

   // Free-running bus clock.
   always #4 hclk = ~hclk;

   timer_pwm timer_pwm_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .tick_in(tick_in), .count_en_in(count_en_in), .tmr_reset_in(tmr_reset_in),
      .capture_in(capture_in), .kill_in(kill_in), .cmp_out(cmp_out),
      .cmp_n_out(cmp_n_out), .tc_out(tc_out), .irq_out(irq_out));

   tick_fabric tick_fabric_i (.hclk(hclk), .hresetn(hresetn), .tick_in(tick_in));

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // One AHB-Lite transfer; the data phase waits for ready like the address phase.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] msk);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(what, exp, q & msk);
   endtask

   function automatic logic [31:0] ctrl_word(input logic [1:0] m, input logic [2:0] r,
                                             input logic [1:0] s);
      return {23'h0, 1'b1, s, r, m, 1'b1};
   endfunction

   function automatic logic exp_cmp(input logic [2:0] r, input logic [15:0] c, v);
      case (r)
         3'h0: return c < v;
         3'h1: return c <= v;
         3'h2: return c == v;
         3'h3: return c >= v;
         3'h4: return c > v;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] next_rnd(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // Stop, load the period and restart in the given mode, relation and source.
   task automatic start(input logic [1:0] m, input logic [2:0] r, input logic [1:0] s,
                        input logic [15:0] per);
      wr(`OFF_CTRL, 32'h0);
      wr(`OFF_PERIOD, {16'h0, per});
      wr(`OFF_CTRL, ctrl_word(m, r, s));
   endtask

   // Counts the steps taken between two reads exactly twelve cycles apart.
   task automatic span(input logic [31:0] exp);
      logic [31:0] a;
      logic [31:0] b;
      xfer(1'b0, `OFF_COUNT, 32'h0, a);
      cyc(10);
      xfer(1'b0, `OFF_COUNT, 32'h0, b);
      chk("count steps", exp, a - b);
   endtask

   // Both halves of the complementary pair must never be high together; sampled mid-cycle.
   always @(negedge hclk) begin
      if (hresetn)
         chk1("pair overlap", 1'b0, cmp_out & cmp_n_out);
   end

   // Cuts a hang short.
   initial begin
      #400000;
      fails++;
      close_out();
   end

   // Main sequence.
   initial begin
      logic [7:0] offs [9];
      logic [31:0] rstv [9];
      logic [15:0] cv;
      logic [31:0] a;
      logic [31:0] b;
      int tcs;
      offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
      rstv = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      wr(8'h20, 32'hFFFF_FFFF);
      for (int i = 0; i < 9; i++)
         rdchk("reset value", offs[i], rstv[i], 32'hFFFF_FFFF);
      // Each source steps once per 1, 2, 3 or 4 cycles; random periods.
      for (int s = 0; s < 4; s++) begin
         rng_r = next_rnd(rng_r);
         start(run_free, cmp_less, s[1:0], 16'h0100 + {6'h0, rng_r[9:0]});
         span(32'(12 / (s + 1)));
      end
      start(run_gated, cmp_less, src_bus, 16'h00C8);
      span(32'h0);
      count_en_in <= 1'b1;
      span(32'hC);
      // Freeze for five edges: only the two edges with the enable high may step.
      xfer(1'b0, `OFF_COUNT, 32'h0, a);
      ce <= 1'b0;
      cyc(5);
      chk1("frozen ready", 1'b0, hreadyout);
      ce <= 1'b1;
      xfer(1'b0, `OFF_COUNT, 32'h0, b);
      chk("frozen steps", 32'h2, a - b);
      count_en_in <= 1'b0;
      start(run_free, cmp_less, src_bus, 16'h03E8);
      tmr_reset_in <= 1'b1;
      cyc(3);
      rdchk("held reload", `OFF_COUNT, 32'h3E8, 32'hFFFF);
      tmr_reset_in <= 1'b0;
      start(run_free, cmp_less, src_bus, 16'h0003);
      cyc(4);
      tcs = 0;
      repeat (40) begin
         @(posedge hclk);
         #1;
         if (tc_out === 1'b1)
            tcs++;
      end
      chk("tc pulses", 32'hA, tcs);
      rdchk("tc status", `OFF_STATUS, 32'h1, 32'h1);
      start(run_one_shot, cmp_less, src_bus, 16'h0005);
      cyc(30);
      rdchk("one-shot run", `OFF_CTRL, 32'h0, 32'h1);
      rdchk("one-shot count", `OFF_COUNT, 32'h5, 32'hFFFF);
      // Held count of 100 against every relation, edge and random values.
      start(run_gated, cmp_less, src_bus, 16'h0064);
      for (int r = 0; r < 6; r++) begin
         for (int k = 0; k < 4; k++) begin
            rng_r = next_rnd(rng_r);
            cv = (k < 3) ? 16'(99 + k) : rng_r[15:0];
            wr(`OFF_COMPARE, {16'h0, cv});
            wr(`OFF_CTRL, ctrl_word(run_gated, r[2:0], src_bus));
            cyc(4);
            chk1("compare out", exp_cmp(r[2:0], 16'h0064, cv), cmp_out);
            chk1("complement out", !exp_cmp(r[2:0], 16'h0064, cv), cmp_n_out);
         end
      end
      wr(`OFF_COMPARE, 32'h64);
      wr(`OFF_CTRL, ctrl_word(run_gated, cmp_less_or_equal, src_bus));
      cyc(4);
      kill_in <= 1'b1;
      cyc(2);
      chk1("killed out", 1'b0, cmp_out);
      chk1("killed complement", 1'b0, cmp_n_out);
      kill_in <= 1'b0;
      cyc(4);
      wr(`OFF_DEADBAND, 32'h6);
      wr(`OFF_COMPARE, 32'h63);
      cyc(3);
      chk1("gap complement", 1'b0, cmp_n_out);
      cyc(10);
      chk1("late complement", 1'b1, cmp_n_out);
      rdchk("compare status", `OFF_STATUS, 32'h2, 32'h2);
      wr(`OFF_STATUS, 32'h7);
      capture_in <= 1'b1;
      cyc(2);
      capture_in <= 1'b0;
      rdchk("captured count", `OFF_CAPTURE, 32'h64, 32'hFFFF_FFFF);
      chk1("bus response", 1'b0, hresp);
      rdchk("capture status", `OFF_STATUS, 32'h4, 32'h7);
      cyc(1);
      chk1("masked irq", 1'b0, irq_out);
      wr(`OFF_MASK, 32'h4);
      cyc(1);
      chk1("raised irq", 1'b1, irq_out);
      wr(`OFF_STATUS, 32'h4);
      cyc(1);
      chk1("cleared irq", 1'b0, irq_out);
      // A capture with its mask bit set raises the interrupt directly.
      capture_in <= 1'b1;
      cyc(2);
      capture_in <= 1'b0;
      chk1("capture irq", 1'b1, irq_out);
      close_out();
   end
endmodule
